// ### core/fault_restart.sv
/*
 * Fault handling and restart sequencing of an analog input unit: conversion
 * data gating, host error and run indicators, setup alarm flags.
 * Assumes all inputs except raw samples come from pins (synchronised here);
 * raw samples and their strobe are on ref_clk.
 */
// Behaviour
// - bus error forces all data to zero
// - missing host response holds data unchanged
// - host watchdog error lights host error and run
// - bad unit number: no conversion, zero, host error
// - table mismatch: host error lit, run off
// - restart bit pulse restarts this unit only
// - zero data while restart is running
// - settings and recovery apply only after restart
// - peak hold changes data only toward peak
// - unused input data never updates
// - setup alarms clear only after restart
`timescale 1ns/1ps
`include "fault_restart_params.svh"
module fault_restart (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic bus_error,
    input wire logic host_timeout,
    input wire logic host_wdt_error,
    input wire logic dup_unit,
    input wire logic table_mismatch,
    input wire logic wide_variant,
    input wire logic restart_bit,
    input wire logic [`FR_UNIT_W-1:0] unit_number,
    input wire logic setup_error,
    input wire logic [`FR_NUM_INPUTS-1:0] input_used,
    input wire logic [`FR_NUM_INPUTS-1:0] peak_hold,
    input wire logic sample_valid,
    input wire logic [`FR_NUM_INPUTS*`FR_DATA_W-1:0] sample_data,
    output logic [`FR_NUM_INPUTS*`FR_DATA_W-1:0] conv_data,
    output logic host_error_indicator,
    output logic run_indicator,
    output logic setup_alarm,
    output logic restarting
);
    localparam int NS = 10;
    // pins: 3-stage sync, change accepted when stages 2 and 3 agree
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] s1_r, s2_r, s3_r, pin_r;
    assign pin_raw = {bus_error, host_timeout, host_wdt_error, dup_unit, table_mismatch,
                      wide_variant, restart_bit, setup_error, 2'b00};
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
        end
    end
    logic [`FR_UNIT_W-1:0] un1_r, un2_r, un3_r, unit_r;
    logic [`FR_NUM_INPUTS-1:0] us1_r, us2_r, us3_r, used_r;
    logic [`FR_NUM_INPUTS-1:0] pk1_r, pk2_r, pk3_r, peak_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {un1_r, un2_r, un3_r, unit_r} <= '0;
            {us1_r, us2_r, us3_r, used_r} <= '0;
            {pk1_r, pk2_r, pk3_r, peak_r} <= '0;
        end else begin
            un1_r <= unit_number;
            un2_r <= un1_r;
            un3_r <= un2_r;
            if (un2_r == un3_r) unit_r <= un3_r;
            us1_r <= input_used;
            us2_r <= us1_r;
            us3_r <= us2_r;
            used_r <= (us2_r & us3_r) | (used_r & (us2_r | us3_r));
            pk1_r <= peak_hold;
            pk2_r <= pk1_r;
            pk3_r <= pk2_r;
            peak_r <= (pk2_r & pk3_r) | (peak_r & (pk2_r | pk3_r));
        end
    end
    wire f_bus = pin_r[9];
    wire f_tmo = pin_r[8];
    wire f_wdt = pin_r[7];
    wire f_dup = pin_r[6];
    wire f_tbl = pin_r[5];
    wire f_wide = pin_r[4];
    wire f_rst = pin_r[3];
    wire f_setup = pin_r[2];
    // restart request on falling edge of the restart bit (set then clear)
    logic rst_bit_d_r;
    wire restart_req = rst_bit_d_r & ~f_rst;
    // the bit position itself is decoded by the host side; the unit sees one line
    wire unit_bad = f_dup || (unit_r > `FR_UNIT_MAX)
                    || (f_wide && unit_r > `FR_UNIT_MAX_WIDE);
    // config latched only at restart so later changes wait for a restart
    logic [`FR_NUM_INPUTS-1:0] used_cfg_r, peak_cfg_r;
    logic unit_bad_r, tbl_bad_r;
    fault_restart_pkg::unit_state_t state_r, state_nxt;
    logic [`FR_CNT_W-1:0] cnt_r;
    wire restart_done = (state_r == fault_restart_pkg::ST_RESTART) && (cnt_r == `FR_CNT_ONE);
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            fault_restart_pkg::ST_RESTART:
                if (restart_done) state_nxt = (unit_bad || f_tbl || f_setup) ?
                    fault_restart_pkg::ST_SETUP_FAULT : fault_restart_pkg::ST_RUN;
            fault_restart_pkg::ST_RUN, fault_restart_pkg::ST_SETUP_FAULT:
                if (restart_req) state_nxt = fault_restart_pkg::ST_RESTART;
        endcase
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= fault_restart_pkg::ST_RESTART;
            cnt_r <= `FR_RESTART_CYCLES;
            rst_bit_d_r <= 1'b0;
            used_cfg_r <= '0;
            peak_cfg_r <= '0;
            unit_bad_r <= 1'b0;
            tbl_bad_r <= 1'b0;
            setup_alarm <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rst_bit_d_r <= f_rst;
            if (state_nxt == fault_restart_pkg::ST_RESTART && state_r != state_nxt)
                cnt_r <= `FR_RESTART_CYCLES;
            else if (cnt_r != `FR_CNT_ZERO)
                cnt_r <= cnt_r - `FR_CNT_ONE;
            if (restart_done) begin
                used_cfg_r <= used_r;
                peak_cfg_r <= peak_r;
                unit_bad_r <= unit_bad;
                tbl_bad_r <= f_tbl;
                setup_alarm <= f_setup;
            end
        end
    end
    wire running = (state_r == fault_restart_pkg::ST_RUN);
    logic [`FR_NUM_INPUTS*`FR_DATA_W-1:0] data_nxt;
    always_comb begin
        data_nxt = conv_data;
        for (int i = 0; i < `FR_NUM_INPUTS; i++) begin
            if (!running || f_bus)
                data_nxt[i*`FR_DATA_W +: `FR_DATA_W] = `FR_ZERO_DATA;
            else if (f_tmo || f_wdt || !sample_valid || !used_cfg_r[i])
                data_nxt[i*`FR_DATA_W +: `FR_DATA_W] =
                    conv_data[i*`FR_DATA_W +: `FR_DATA_W];
            else if (!peak_cfg_r[i] || $signed(sample_data[i*`FR_DATA_W +: `FR_DATA_W])
                     > $signed(conv_data[i*`FR_DATA_W +: `FR_DATA_W]))
                data_nxt[i*`FR_DATA_W +: `FR_DATA_W] =
                    sample_data[i*`FR_DATA_W +: `FR_DATA_W];
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_data <= '0;
            host_error_indicator <= 1'b0;
            run_indicator <= 1'b0;
            restarting <= 1'b1;
        end else begin
            conv_data <= data_nxt;
            // wdt: data left as held, the host must not trust it
            host_error_indicator <= f_wdt
                || (state_r == fault_restart_pkg::ST_SETUP_FAULT
                    && (unit_bad_r || tbl_bad_r));
            run_indicator <= f_wdt || running;
            restarting <= (state_nxt == fault_restart_pkg::ST_RESTART);
        end
    end

    run_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $past(f_bus) |-> conv_data == '0) else $error("data not zero on bus error");
    hold_tmo_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        running && f_tmo && !f_bus && $past(running) |=> $stable(conv_data))
        else $error("data moved during host timeout");
    wdt_leds_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        f_wdt |=> host_error_indicator && run_indicator)
        else $error("watchdog indicators wrong");
    bad_unit_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_r == fault_restart_pkg::ST_SETUP_FAULT && !f_wdt |=>
        !run_indicator && conv_data == '0) else $error("setup fault output wrong");
    tbl_led_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_r == fault_restart_pkg::ST_SETUP_FAULT && tbl_bad_r |=> host_error_indicator)
        else $error("table mismatch not shown");
    unit_led_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_r == fault_restart_pkg::ST_SETUP_FAULT && unit_bad_r |=> host_error_indicator)
        else $error("bad unit number not shown");
    run_led_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        running |=> run_indicator)
        else $error("run indicator off while running");
    sequence bit_pulse_s;
        f_rst ##1 !f_rst;
    endsequence
    restart_seq_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bit_pulse_s |=> state_r == fault_restart_pkg::ST_RESTART ##1 restarting[*8])
        else $error("restart pulse ignored");
    restart_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        state_r == fault_restart_pkg::ST_RESTART |=> conv_data == '0)
        else $error("data not zero in restart");
    cfg_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !restart_done |=> $stable(used_cfg_r) && $stable(setup_alarm))
        else $error("config changed outside restart");
    peak_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        running && !f_bus && peak_cfg_r[0] && $past(running) |=>
        $signed(conv_data[`FR_DATA_W-1:0]) >= $signed($past(conv_data[`FR_DATA_W-1:0])))
        else $error("peak hold fell");
    unused_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        running && !f_bus && !used_cfg_r[0] && $past(running) |=>
        $stable(conv_data[`FR_DATA_W-1:0])) else $error("unused input updated");
endmodule : fault_restart

// ### common/fault_restart_params.svh
/*
 * Constants for the input unit fault and restart logic.
 * Assumes inclusion by bare name from design files.
 */
`ifndef FAULT_RESTART_PARAMS_SVH
`define FAULT_RESTART_PARAMS_SVH
`define FR_NUM_INPUTS 8
`define FR_DATA_W 16
`define FR_UNIT_W 7
`define FR_UNIT_MAX 7'h5f
`define FR_UNIT_MAX_WIDE 7'h5e
`define FR_ZERO_DATA 16'h0000
`define FR_RESTART_CYCLES 8'h10
`define FR_CNT_W 8
`define FR_CNT_ZERO 8'h00
`define FR_CNT_ONE 8'h01
`endif

// ### common/fault_restart_pkg.sv
/*
 * Types for the input unit fault and restart logic.
 * Assumes the params header supplies the widths.
 */
`include "fault_restart_params.svh"
package fault_restart_pkg;
    typedef enum logic [1:0] {ST_RESTART, ST_RUN, ST_SETUP_FAULT} unit_state_t;
    typedef logic [`FR_DATA_W-1:0] sample_t;
endpackage : fault_restart_pkg

// ### verification/host_cpu_model.sv
/*
 * Controller CPU stand-in: pulses this unit's restart bit on request.
 * Assumes restart_go is a one-cycle request on ref_clk.
 */
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic restart_go,
    output logic restart_bit
);
    logic [2:0] cnt_r;
    // high six cycles then low, longer than the unit's pin filter
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 3'h0;
            restart_bit <= 1'b0;
        end else if (restart_go && cnt_r == 3'h0) begin
            cnt_r <= 3'h6;
            restart_bit <= 1'b1;
        end else if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
            restart_bit <= (cnt_r != 3'h1);
        end
    end
endmodule : host_cpu_model

// ### verification/input_unit_fault_restart_logic_tb.sv
/*
 * Self-checking bench for the fault and restart logic.
 * Assumes pin changes are seen within 8 cycles and restart bit via model.
 */
`timescale 1ns/1ps
`include "fault_restart_params.svh"
module input_unit_fault_restart_logic_tb;
    logic ref_clk, reset_n, bus_error, host_timeout, host_wdt_error, dup_unit;
    logic table_mismatch, wide_variant, restart_bit, restart_go, setup_error;
    logic sample_valid, host_error_indicator, run_indicator, setup_alarm;
    logic restarting;
    logic [6:0] unit_number;
    logic [7:0] input_used, peak_hold;
    logic [127:0] sample_data, conv_data;
    int num_errors = 0;
    int compares = 0;
    fault_restart u_dut (.*);
    host_cpu_model u_cpu (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic settle;
        repeat (8) @(posedge ref_clk);
    endtask : settle
    task automatic flags(input logic h, input logic r, input logic s);
        chk({host_error_indicator, run_indicator, setup_alarm}, {h, r, s});
    endtask : flags
    task automatic wait_restart(input bit pulse);
        int n;
        if (pulse) begin
            restart_go <= 1'b1;
            @(posedge ref_clk);
            restart_go <= 1'b0;
            for (n = 0; n < 40 && restarting !== 1'b1; n++) @(posedge ref_clk);
            // a pulse that never starts a restart must not pass silently
            if (restarting !== 1'b1) begin
                num_errors++;
                report_and_stop;
            end
        end
        @(posedge ref_clk);
        chk(conv_data, 128'h0);
        for (n = 0; n < 60 && restarting !== 1'b0; n++) @(posedge ref_clk);
        if (n == 60) begin
            num_errors++;
            report_and_stop;
        end
        settle;
    endtask : wait_restart
    task automatic t_bus_and_timeout;
        bus_error <= 1'b1;
        settle;
        chk(conv_data, 128'h0);
        bus_error <= 1'b0;
        settle;
        chk(conv_data, {8{16'h0100}});
        // held value must be non-zero so a zeroing design would be caught
        host_timeout <= 1'b1;
        settle;
        sample_data <= {8{16'h0200}};
        settle;
        chk(conv_data, {8{16'h0100}});
        host_timeout <= 1'b0;
        settle;
        chk(conv_data, {8{16'h0200}});
        host_wdt_error <= 1'b1;
        settle;
        flags(1'b1, 1'b1, 1'b0);
        host_wdt_error <= 1'b0;
        settle;
    endtask : t_bus_and_timeout
    task automatic t_unit_faults;
        unit_number <= 7'h60;
        wait_restart(1'b1);
        flags(1'b1, 1'b0, 1'b0);
        chk(conv_data, 128'h0);
        wide_variant <= 1'b1;
        unit_number <= 7'h5f;
        wait_restart(1'b1);
        flags(1'b1, 1'b0, 1'b0);
        wide_variant <= 1'b0;
        dup_unit <= 1'b1;
        wait_restart(1'b1);
        flags(1'b1, 1'b0, 1'b0);
        dup_unit <= 1'b0;
        table_mismatch <= 1'b1;
        wait_restart(1'b1);
        flags(1'b1, 1'b0, 1'b0);
        table_mismatch <= 1'b0;
        setup_error <= 1'b1;
        wait_restart(1'b1);
        flags(1'b0, 1'b0, 1'b1);
        setup_error <= 1'b0;
        settle;
        flags(1'b0, 1'b0, 1'b1);
        wait_restart(1'b1);
        flags(1'b0, 1'b1, 1'b0);
    endtask : t_unit_faults
    task automatic t_peak_unused;
        peak_hold <= 8'h01;
        input_used <= 8'h7f;
        wait_restart(1'b1);
        sample_data <= {8{16'h0050}};
        settle;
        chk(conv_data, {16'h0000, {6{16'h0050}}, 16'h0200});
        sample_data <= {8{16'h0300}};
        settle;
        chk(conv_data, {16'h0000, {7{16'h0300}}});
    endtask : t_peak_unused
    initial begin
        {reset_n, bus_error, host_timeout, host_wdt_error, dup_unit} = 5'h0;
        {table_mismatch, wide_variant, restart_go, setup_error} = 4'h0;
        unit_number = 7'h05;
        input_used = 8'hff;
        peak_hold = 8'h00;
        sample_valid = 1'b1;
        sample_data = {8{16'h0100}};
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        wait_restart(1'b0);
        chk(conv_data, {8{16'h0100}});
        t_bus_and_timeout;
        t_unit_faults;
        t_peak_unused;
        report_and_stop;
    end
endmodule : input_unit_fault_restart_logic_tb
